/* File: design/radio_power_mode_sequencer.sv */
// operating-mode sequencer: gates oscillators, paths and clock output
//
// Operation
// - decode mode: sleep, standby, synth, rx, tx
// - no buffered clock output while sleeping
// - crystal usable within 5 ms after wake
// - pll locks under 0.5 ms after synth
// - lock state shown on dedicated pin
// - whole wake-up path under 6 ms
// - return to sleep within 1 ms
// - status 1 unlocked; disable forces pin high
`timescale 1ns/1ns
`include "radio_mode_regs.svh"
module radio_power_mode_sequencer #(
  parameter int XTAL_WAKE_CYC = `XTAL_WAKE_US * `CLK_MHZ,
  parameter int PLL_LOCK_CYC  = `PLL_LOCK_US * `CLK_MHZ,
  parameter int WAKE_TOT_CYC  = `WAKE_TOTAL_US * `CLK_MHZ,
  parameter int SLEEP_CYC     = `SLEEP_ENTRY_US * `CLK_MHZ
) (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic [`MODE_W-1:0] main_mode,
  input  wire logic               lock_out_dis,
  output logic                    xtal_en,
  output logic                    xtal_ready,
  output logic                    pll_en,
  output logic                    rx_en,
  output logic                    tx_en,
  output logic                    clk_out,
  output logic                    clk_out_oe,
  output logic                    lock_pin,
  output logic                    lock_status
);
  //////////////////////////////////////////////////////////////////////////
  // reset release through two flip-flops
  logic rst_meta_r;  // first stage, read only by the second
  logic rst_n_r;     // synchronised reset used everywhere below

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_r <= `OUT_OFF;
      rst_n_r    <= `OUT_OFF;
    end else begin
      rst_meta_r <= `OUT_ON;
      rst_n_r    <= rst_meta_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // settle timers for crystal start and pll lock
  settle_tmr_if xt_if ();  // crystal start-up timer
  settle_tmr_if pl_if ();  // pll lock timer

  settle_timer u_xtal_tmr (
    .clk   (clk),
    .rst_n (rst_n_r),
    .tmr   (xt_if.tmr)
  );

  settle_timer u_pll_tmr (
    .clk   (clk),
    .rst_n (rst_n_r),
    .tmr   (pl_if.tmr)
  );

  //////////////////////////////////////////////////////////////////////////
  // sequencer state and registered outputs
  radio_mode_pkg::seq_state_e state_r;   // current operating state
  radio_mode_pkg::seq_state_e state_nxt;
  logic xtal_en_r,  xtal_en_nxt;         // crystal oscillator enable
  logic xrdy_r,     xrdy_nxt;            // crystal usable
  logic pll_en_r,   pll_en_nxt;          // synthesizer enable
  logic rx_en_r,    rx_en_nxt;           // receive path enable
  logic tx_en_r,    tx_en_nxt;           // transmit path enable
  logic clk_oe_r,   clk_oe_nxt;          // clock output driven
  logic clk_r,      clk_nxt;             // buffered clock level
  logic lpin_r,     lpin_nxt;            // lock pin level
  logic lstat_r,    lstat_nxt;           // lock status, 1 unlocked
  logic locked;                          // pll locked in next state

  // next state and outputs
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      radio_mode_pkg::ST_SLEEP: begin
        // any awake code starts the crystal first
        if (main_mode != `MODE_SLEEP) begin
          state_nxt = radio_mode_pkg::ST_XTAL_WAIT;
        end
      end
      radio_mode_pkg::ST_XTAL_WAIT: begin
        if (main_mode == `MODE_SLEEP) begin
          state_nxt = radio_mode_pkg::ST_SLEEP;
        end else if (xt_if.done) begin
          state_nxt = radio_mode_pkg::ST_STANDBY;
        end
      end
      radio_mode_pkg::ST_STANDBY: begin
        if (main_mode == `MODE_SLEEP) begin
          state_nxt = radio_mode_pkg::ST_SLEEP;
        end else if (main_mode == `MODE_SYNTH ||
                     main_mode == `MODE_RX ||
                     main_mode == `MODE_TX) begin
          state_nxt = radio_mode_pkg::ST_PLL_WAIT;
        end
      end
      radio_mode_pkg::ST_PLL_WAIT: begin
        if (main_mode == `MODE_SLEEP) begin
          state_nxt = radio_mode_pkg::ST_SLEEP;
        end else if (main_mode != `MODE_SYNTH &&
                     main_mode != `MODE_RX &&
                     main_mode != `MODE_TX) begin
          state_nxt = radio_mode_pkg::ST_STANDBY;
        end else if (pl_if.done) begin
          state_nxt = radio_mode_pkg::ST_LOCKED;
        end
      end
      radio_mode_pkg::ST_LOCKED, radio_mode_pkg::ST_RX,
      radio_mode_pkg::ST_TX: begin
        // paths open only from a locked synthesizer
        case (main_mode)
          `MODE_SLEEP: state_nxt = radio_mode_pkg::ST_SLEEP;
          `MODE_SYNTH: state_nxt = radio_mode_pkg::ST_LOCKED;
          `MODE_RX:    state_nxt = radio_mode_pkg::ST_RX;
          `MODE_TX:    state_nxt = radio_mode_pkg::ST_TX;
          default:     state_nxt = radio_mode_pkg::ST_STANDBY;
        endcase
      end
      default: begin
        state_nxt = radio_mode_pkg::ST_SLEEP;
      end
    endcase

    // outputs follow the next state so they change with it
    locked      = (state_nxt == radio_mode_pkg::ST_LOCKED ||
                   state_nxt == radio_mode_pkg::ST_RX ||
                   state_nxt == radio_mode_pkg::ST_TX);
    xtal_en_nxt = (state_nxt != radio_mode_pkg::ST_SLEEP);
    xrdy_nxt    = xtal_en_nxt &&
                  (state_nxt != radio_mode_pkg::ST_XTAL_WAIT);
    pll_en_nxt  = locked ||
                  (state_nxt == radio_mode_pkg::ST_PLL_WAIT);
    rx_en_nxt   = (state_nxt == radio_mode_pkg::ST_RX);
    tx_en_nxt   = (state_nxt == radio_mode_pkg::ST_TX);
    clk_oe_nxt  = xrdy_nxt;
    clk_nxt     = xrdy_nxt ? ~clk_r : `OUT_OFF;
    lstat_nxt   = ~locked;
    lpin_nxt    = lock_out_dis ? `OUT_ON : locked;
  end

  // register state and outputs
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r   <= radio_mode_pkg::ST_SLEEP;
      xtal_en_r <= `OUT_OFF;
      xrdy_r    <= `OUT_OFF;
      pll_en_r  <= `OUT_OFF;
      rx_en_r   <= `OUT_OFF;
      tx_en_r   <= `OUT_OFF;
      clk_oe_r  <= `OUT_OFF;
      clk_r     <= `OUT_OFF;
      lpin_r    <= `OUT_ON;
      lstat_r   <= `OUT_ON;
    end else begin
      state_r   <= state_nxt;
      xtal_en_r <= xtal_en_nxt;
      xrdy_r    <= xrdy_nxt;
      pll_en_r  <= pll_en_nxt;
      rx_en_r   <= rx_en_nxt;
      tx_en_r   <= tx_en_nxt;
      clk_oe_r  <= clk_oe_nxt;
      clk_r     <= clk_nxt;
      lpin_r    <= lpin_nxt;
      lstat_r   <= lstat_nxt;
    end
  end

  // timers run only while their state waits on them; the wait state lasts
  // one cycle longer than the load, so loads are trimmed to keep the
  // crystal within its limit and the pll strictly under its limit
  assign xt_if.run  = (state_r == radio_mode_pkg::ST_XTAL_WAIT);
  assign xt_if.load = `TMR_W'(XTAL_WAKE_CYC - 1);
  assign pl_if.run  = (state_r == radio_mode_pkg::ST_PLL_WAIT);
  assign pl_if.load = `TMR_W'(PLL_LOCK_CYC - 2);

  assign xtal_en     = xtal_en_r;
  assign xtal_ready  = xrdy_r;
  assign pll_en      = pll_en_r;
  assign rx_en       = rx_en_r;
  assign tx_en       = tx_en_r;
  assign clk_out     = clk_r;
  assign clk_out_oe  = clk_oe_r;
  assign lock_pin    = lpin_r;
  assign lock_status = lstat_r;

  //////////////////////////////////////////////////////////////////////////
  // helper counters for the checks below
  logic [31:0] xw_cnt_r;  // cycles spent waiting for the crystal
  logic [31:0] pw_cnt_r;  // cycles spent waiting for lock
  logic [31:0] wk_cnt_r;  // device wait cycles of one wake-up

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      xw_cnt_r <= 32'h0;
      pw_cnt_r <= 32'h0;
      wk_cnt_r <= 32'h0;
    end else begin
      xw_cnt_r <= (state_r == radio_mode_pkg::ST_XTAL_WAIT) ?
                  xw_cnt_r + 32'h1 : 32'h0;
      pw_cnt_r <= (state_r == radio_mode_pkg::ST_PLL_WAIT) ?
                  pw_cnt_r + 32'h1 : 32'h0;
      if (state_r == radio_mode_pkg::ST_SLEEP) begin
        wk_cnt_r <= 32'h0;
      end else if (state_r == radio_mode_pkg::ST_XTAL_WAIT ||
                   state_r == radio_mode_pkg::ST_PLL_WAIT) begin
        wk_cnt_r <= wk_cnt_r + 32'h1;
      end
    end
  end

  property p_decode_tx;
    @(posedge clk) disable iff (!rst_n_r)
    (state_r == radio_mode_pkg::ST_LOCKED && main_mode == `MODE_TX)
      |=> (tx_en && !rx_en && pll_en && xtal_en);
  endproperty
  a_decode_tx: assert property (p_decode_tx)
    else $error("transmit code did not open the transmit path");

  property p_sleep_no_clk;
    @(posedge clk) disable iff (!rst_n_r)
    (main_mode == `MODE_SLEEP) |=> (!clk_out_oe && !clk_out);
  endproperty
  a_sleep_no_clk: assert property (p_sleep_no_clk)
    else $error("clock output driven in sleep");

  property p_xtal_bound;
    @(posedge clk) disable iff (!rst_n_r)
    xw_cnt_r <= XTAL_WAKE_CYC;
  endproperty
  a_xtal_bound: assert property (p_xtal_bound)
    else $error("crystal wake exceeded its limit");

  property p_pll_bound;
    @(posedge clk) disable iff (!rst_n_r)
    pw_cnt_r < PLL_LOCK_CYC;
  endproperty
  a_pll_bound: assert property (p_pll_bound)
    else $error("pll lock exceeded its limit");

  property p_lock_pin;
    @(posedge clk) disable iff (!rst_n_r)
    !lock_out_dis |=> (lock_pin == !lock_status);
  endproperty
  a_lock_pin: assert property (p_lock_pin)
    else $error("lock pin disagrees with lock status");

  property p_wake_total;
    @(posedge clk) disable iff (!rst_n_r)
    wk_cnt_r < WAKE_TOT_CYC;
  endproperty
  a_wake_total: assert property (p_wake_total)
    else $error("wake-up path exceeded its limit");

  property p_sleep_entry;
    @(posedge clk) disable iff (!rst_n_r)
    (main_mode == `MODE_SLEEP) |=>
      (!xtal_en && !pll_en && !rx_en && !tx_en &&
       state_r == radio_mode_pkg::ST_SLEEP);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("sleep not reached after sleep code");

  property p_lock_dis;
    @(posedge clk) disable iff (!rst_n_r)
    lock_out_dis |=> lock_pin;
  endproperty
  a_lock_dis: assert property (p_lock_dis)
    else $error("lock pin not forced high while disabled");
endmodule

/* File: design/settle_timer.sv */
// settle timer: pulses done after load cycles of run
`timescale 1ns/1ns
`include "radio_mode_regs.svh"
module settle_timer (
  input  wire logic   clk,
  input  wire logic   rst_n,
  settle_tmr_if.tmr   tmr
);
  radio_mode_pkg::tmr_cnt_t cnt_r;   // remaining cycles
  radio_mode_pkg::tmr_cnt_t cnt_nxt;
  logic                     done_r;  // expiry pulse
  logic                     done_nxt;

  //////////////////////////////////////////////////////////////////////////
  // next-state of the countdown
  always_comb begin
    cnt_nxt  = cnt_r;
    done_nxt = `OUT_OFF;
    if (!tmr.run) begin
      // idle: hold the reload value
      cnt_nxt = tmr.load;
    end else if (cnt_r != `CNT_ZERO) begin
      // running: count down, pulse on the last step
      cnt_nxt  = cnt_r - `CNT_ONE;
      done_nxt = (cnt_r == `CNT_ONE);
    end
  end

  // register the countdown
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r  <= `CNT_ZERO;
      done_r <= `OUT_OFF;
    end else begin
      cnt_r  <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign tmr.done = done_r;
endmodule

/* File: inc/radio_mode_pkg.sv */
// types of the radio operating-mode sequencer
package radio_mode_pkg;
  `include "radio_mode_regs.svh"

  // sequencer states
  typedef enum logic [2:0] {
    ST_SLEEP     = 3'b000,
    ST_XTAL_WAIT = 3'b001,
    ST_STANDBY   = 3'b010,
    ST_PLL_WAIT  = 3'b011,
    ST_LOCKED    = 3'b100,
    ST_RX        = 3'b101,
    ST_TX        = 3'b110
  } seq_state_e;

  typedef logic [`TMR_W-1:0] tmr_cnt_t;
endpackage

/* File: inc/radio_mode_regs.svh */
// constants of the radio operating-mode sequencer
`ifndef RADIO_MODE_REGS_SVH
`define RADIO_MODE_REGS_SVH

// operating-mode field codes
`define MODE_SLEEP      3'h0
`define MODE_STANDBY    3'h1
`define MODE_SYNTH      3'h2
`define MODE_RX         3'h3
`define MODE_TX         3'h4

// field width and timer width
`define MODE_W          3
`define TMR_W           20

// clock rate and documented timing limits, in microseconds
`define CLK_MHZ         100
`define XTAL_WAKE_US    5000
`define PLL_LOCK_US     500
`define WAKE_TOTAL_US   6000
`define SLEEP_ENTRY_US  1000

// reset values of outputs, and countdown zero and one
`define OUT_OFF         1'h0
`define OUT_ON          1'h1
`define CNT_ZERO        20'h00000
`define CNT_ONE         20'h00001

`endif

/* File: inc/settle_tmr_if.sv */
// carrier between the sequencer and a settle timer
`timescale 1ns/1ns
interface settle_tmr_if;
  logic                       run;   // count while high, reload while low
  radio_mode_pkg::tmr_cnt_t   load;  // cycles until done
  logic                       done;  // one-cycle pulse at expiry

  modport ctl (output run, output load, input done);
  modport tmr (input run, input load, output done);
endinterface

/* File: tb/host_mode_model.sv */
// host model stepping the operating-mode field
`timescale 1ns/1ns
`include "radio_mode_regs.svh"
module host_mode_model (
  input  wire logic               clk,
  input  wire logic [`MODE_W-1:0] req_mode,
  input  wire logic               obey,
  input  wire logic               xtal_ready,
  input  wire logic               lock_pin,
  output logic      [`MODE_W-1:0] main_mode,
  output logic                    busy,
  output logic                    config_port_select_n,
  output logic                    buffer_port_select_n,
  output logic                    sdi,
  output logic                    sck
);
  // serial lines parked low, buffer select high while asleep
  assign config_port_select_n = (main_mode != `MODE_SLEEP);
  assign buffer_port_select_n = 1'h1;
  assign sdi = 1'h0;
  assign sck = 1'h0;
  initial begin
    main_mode = `MODE_SLEEP;
    busy = 1'h0;
  end
  // walk through standby and synth; obey low skips the lock wait
  always begin
    @(posedge clk);
    if (req_mode != main_mode) begin
      // busy rises only where a wait follows, never twice in one step
      if (req_mode != `MODE_SLEEP && main_mode == `MODE_SLEEP) begin
        busy <= 1'h1;
        main_mode <= `MODE_STANDBY;
        do @(posedge clk); while (!xtal_ready);
      end
      if (req_mode > `MODE_STANDBY) begin
        busy <= 1'h1;
        main_mode <= `MODE_SYNTH;
        do @(posedge clk); while (obey && !lock_pin);
      end
      main_mode <= req_mode;
      busy <= 1'h0;
    end
  end
endmodule

/* File: tb/radio_power_mode_sequencer_tb.sv */
// testbench of the radio operating-mode sequencer
`timescale 1ns/1ns
`include "radio_mode_regs.svh"
module radio_power_mode_sequencer_tb;
  localparam int XW = 20; // shortened crystal wake
  localparam int PL = 10; // shortened pll lock
  localparam int WT = 60; // shortened total wake
  localparam int SL = 10; // shortened sleep entry
  typedef struct {logic [7:0] exp; logic [7:0] msk;} note_s;
  logic               clk, rstn, lock_out_dis, obey, busy, c0;
  logic [`MODE_W-1:0] req, main_mode;
  logic               xtal_en, xtal_ready, pll_en, rx_en, tx_en;
  logic               clk_out, clk_out_oe, lock_pin, lock_status;
  logic [7:0]         seed, outs;
  note_s              q[$];
  int                 n_fail, check_count, cyc, dur, tot;
  // outputs gathered for comparison
  assign outs = {xtal_en, xtal_ready, pll_en, rx_en, tx_en, clk_out_oe,
                 lock_pin, lock_status};
  always #5 clk = ~clk;
  radio_power_mode_sequencer #(.XTAL_WAKE_CYC(XW), .PLL_LOCK_CYC(PL),
    .WAKE_TOT_CYC(WT), .SLEEP_CYC(SL)) u_radio_power_mode_sequencer (
    .clk(clk), .rstn(rstn), .main_mode(main_mode),
    .lock_out_dis(lock_out_dis), .xtal_en(xtal_en),
    .xtal_ready(xtal_ready), .pll_en(pll_en), .rx_en(rx_en),
    .tx_en(tx_en), .clk_out(clk_out), .clk_out_oe(clk_out_oe),
    .lock_pin(lock_pin), .lock_status(lock_status));
  host_mode_model u_host_mode_model (
    .clk(clk), .req_mode(req), .obey(obey), .xtal_ready(xtal_ready),
    .lock_pin(lock_pin), .main_mode(main_mode), .busy(busy),
    .config_port_select_n(), .buffer_port_select_n(), .sdi(), .sck());
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // queue an expected output vector
  task automatic note(input logic [7:0] e, input logic [7:0] m);
    q.push_back('{e, m});
  endtask
  // ask the host for a mode; dur is the cycles it took
  task automatic go(input logic [2:0] m);
    int n;
    n = 0;
    @(posedge clk);
    req <= m;
    repeat (2) @(negedge clk);
    while (busy && n < 1000) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    dur = n + 3;
  endtask
  task automatic set_dis(input logic b);
    @(posedge clk);
    lock_out_dis <= b;
    repeat (3) @(negedge clk);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // monitor: oldest note against settled outputs
  always @(negedge clk) begin
    if (q.size() > 0) begin
      chk(outs & q[0].msk, q[0].exp & q[0].msk);
      q.delete(0);
    end
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'h0;
    rstn = 1'h0;
    req = `MODE_SLEEP;
    obey = 1'h1;
    lock_out_dis = 1'h0;
    seed = 8'h22;
    repeat (10) @(posedge clk);
    rstn <= 1'h1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    note(8'h01, 8'hFD);
    chk({7'h00, clk_out}, 8'h00);
    $display("test reset done");
    // full wake to rx or tx and back, random path and disable bit
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      go(`MODE_STANDBY);
      chk(8'(dur <= XW + 10), 8'h01);
      tot = dur;
      note(8'hC5, 8'hFF);
      c0 = clk_out;
      @(negedge clk);
      chk(8'(clk_out != c0), 8'h01);
      set_dis(seed[0]);
      note({6'h31, seed[0], 1'h1}, 8'hFF);
      set_dis(1'h0);
      go(`MODE_SYNTH);
      chk(8'(dur <= PL + 10), 8'h01);
      tot += dur;
      note(8'hE6, 8'hFF);
      go(seed[1] ? `MODE_TX : `MODE_RX);
      tot += dur;
      chk(8'(tot < WT), 8'h01);
      note(seed[1] ? 8'hEE : 8'hF6, 8'hFF);
      go(`MODE_SLEEP);
      chk(8'(dur <= SL), 8'h01);
      note(8'h01, 8'hFD);
    end
    $display("test wake done");
    // receive asked before lock: held off until lock
    go(`MODE_STANDBY);
    @(posedge clk);
    obey <= 1'h0;
    go(`MODE_RX);
    note(8'hE5, 8'hFF);
    repeat (PL + 4) @(negedge clk);
    note(8'hF6, 8'hFF);
    @(posedge clk);
    obey <= 1'h1;
    go(`MODE_STANDBY);
    note(8'hC5, 8'hFF);
    // unused code from a locked synthesizer falls back to standby
    go(3'h7);
    note(8'hC5, 8'hFF);
    go(`MODE_SLEEP);
    note(8'h01, 8'hFD);
    $display("test early receive done");
    repeat (3) @(negedge clk);
    summarize();
  end
endmodule
